/* common/hbp_pkg.sv */
// Package: constants, types and state layout for the host bus port
package hbp_pkg;

  // Register indices as seen on the five select lines
  localparam logic [4:0] REG_GPIO_DATA = 5'h00;
  localparam logic [4:0] REG_EDGE_SEL = 5'h01;
  localparam logic [4:0] REG_DIRECTION = 5'h02;
  localparam logic [4:0] REG_ENABLE_A = 5'h03;
  localparam logic [4:0] REG_ENABLE_B = 5'h04;
  localparam logic [4:0] REG_PENDING_A = 5'h05;
  localparam logic [4:0] REG_PENDING_B = 5'h06;
  localparam logic [4:0] REG_INSERVICE_A = 5'h07;
  localparam logic [4:0] REG_INSERVICE_B = 5'h08;
  localparam logic [4:0] REG_MASK_A = 5'h09;
  localparam logic [4:0] REG_MASK_B = 5'h0a;
  localparam logic [4:0] REG_VECTOR = 5'h0b;
  localparam logic [4:0] REG_TIMER_A_CTRL = 5'h0c;
  localparam logic [4:0] REG_TIMER_B_CTRL = 5'h0d;

  // Reset values
  localparam logic [7:0] VECTOR_RESET = 8'h0f;
  localparam logic [7:0] REG_CLEAR = 8'h00;

  // Timer control mode field: set means pulse width or event count
  localparam int TMR_MODE_BIT = 3;

  // Interrupt channels of the general purpose lines, line 0 upward
  localparam logic [63:0] GP_CHANNEL_MAP = 64'hfe76_3210_0000_0000;
  // Channels of the eight internal sources, source 0 upward
  localparam logic [31:0] INT_CHANNEL_MAP = 32'hdcba_9854;
  // Lines whose interrupt a timer control input takes over
  localparam int TAI_LINE = 4;
  localparam int TBI_LINE = 3;

  // Bus cycle states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_INTERRUPT_ACK_N,
    ST_PASS,
    ST_END
  } hbp_bus_state_t;

  // Strobe group taken through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic interrupt_ack_n_n;
    logic as;
  } hbp_ctl_t;

  localparam hbp_ctl_t CTL_IDLE = '{cs_n: 1'b1, ds_n: 1'b1, interrupt_ack_n_n: 1'b1, as: 1'b0};

  // Synchroniser state
  typedef struct packed {
    hbp_ctl_t meta;
    hbp_ctl_t stable;
  } hbp_sync_state_t;

  // Whole state of the port
  typedef struct packed {
    hbp_bus_state_t st;
    logic [4:0] idx;
    logic [4:0] addr_latch;
    logic as_prev;
    logic [7:0] wdata;
    logic [7:0] gpio_data;
    logic [7:0] edge_sel;
    logic [7:0] direction;
    logic [15:0] enable;
    logic [15:0] pending;
    logic [15:0] mask;
    logic [7:0] vector;
    logic [7:0] timer_a_ctrl;
    logic [7:0] timer_b_ctrl;
    logic [7:0] line_prev;
    logic [7:0] dout;
    logic dout_oe;
    logic ack_n;
    logic ack_oe;
    logic irq_n;
    logic irq_oe;
    logic chain_out_n;
    logic [2:0] tout;
    logic rx_req_n;
    logic tx_req_n;
    logic ext_wr;
    logic [4:0] ext_idx;
    logic [7:0] ext_wdata;
  } hbp_state_t;

endpackage

/* hdl/hbp_sync.sv */
// Two-stage synchroniser for the bus strobe group
`timescale 1ns/1ns
`default_nettype none
module hbp_sync (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Raw and synchronised strobes
  input var hbp_pkg::hbp_ctl_t raw_i,
  output var hbp_pkg::hbp_ctl_t sync_o
);

  hbp_pkg::hbp_sync_state_t s_reg;
  hbp_pkg::hbp_sync_state_t s_next;

  // First stage feeds only the second stage
  always_comb begin
    s_next = s_reg;
    s_next.meta = raw_i;
    s_next.stable = s_reg.meta;
  end

  // Reset to inactive strobes so no cycle starts out of reset
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      s_reg <= '{meta: hbp_pkg::CTL_IDLE, stable: hbp_pkg::CTL_IDLE};
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_o = s_reg.stable;

endmodule // hbp_sync
`default_nettype wire

/* hdl/hbp_prio.sv */
// Fixed priority encoder over the sixteen interrupt channels
`timescale 1ns/1ns
`default_nettype none
module hbp_prio (
  // Requests, channel 15 highest
  input wire logic [15:0] req_i,
  // Winner
  output logic any_o,
  output logic [3:0] chan_o
);

  // Later iterations overwrite, so the highest channel wins
  always_comb begin
    any_o = 1'b0;
    chan_o = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        chan_o = 4'(i);
      end
    end
  end

endmodule // hbp_prio
`default_nettype wire

/* hdl/hbp_host_port.sv */
// Host bus port, interrupt controller core and pin hooks
`timescale 1ns/1ns
`default_nettype none
module hbp_host_port (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Host bus control
  input wire logic cs_n_i,
  input wire logic data_strobe_n_i,
  input wire logic rw_i,
  input wire logic [4:0] register_select_i,
  input wire logic bus_mux_select_i,
  input wire logic addr_strobe_i,
  // Data bus, split into three signals
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Acknowledge, three-state
  output logic transfer_ack_n_o,
  output logic transfer_ack_oe_o,
  // Interrupt request, open drain
  output logic irq_n_o,
  output logic irq_oe_o,
  // Interrupt acknowledge and chain
  input wire logic interrupt_ack_n_i,
  input wire logic chain_enable_in_n_i,
  output logic chain_enable_out_n_o,
  // General purpose lines
  input wire logic [7:0] general_purpose_lines_i,
  output logic [7:0] general_purpose_lines_o,
  output logic [7:0] general_purpose_lines_oe_o,
  // Timer hooks
  input wire logic timer_a_control_input_i,
  input wire logic timer_b_control_input_i,
  input wire logic [2:0] timer_cycle_i,
  output logic timer_a_output_o,
  output logic timer_b_output_o,
  output logic timer_c_output_o,
  // Serial and internal event hooks
  input wire logic rx_full_i,
  input wire logic tx_empty_i,
  input wire logic [7:0] internal_event_i,
  // DMA handshake requests, active low
  output logic rx_full_dma_req_n_o,
  output logic send_empty_dma_req_n_o,
  // Registers held outside this block
  input wire logic [7:0] ext_rdata_i,
  output logic ext_wr_o,
  output logic [4:0] ext_idx_o,
  output logic [7:0] ext_wdata_o
);

  hbp_pkg::hbp_state_t s_reg;
  hbp_pkg::hbp_state_t s_next;
  hbp_pkg::hbp_ctl_t ctl_raw;
  hbp_pkg::hbp_ctl_t ctl;
  logic [7:0] line_src;
  logic [7:0] line_ev;
  logic [15:0] chan_ev;
  logic [15:0] active;
  logic irq_any;
  logic [3:0] irq_chan;

  // True when the index names a register kept inside this block
  function automatic logic is_local(input logic [4:0] idx);
    return idx <= hbp_pkg::REG_TIMER_B_CTRL;
  endfunction

  // True when the mode field selects pulse width or event count
  function automatic logic timer_gated(input logic [7:0] ctrl);
    return ctrl[hbp_pkg::TMR_MODE_BIT];
  endfunction

  // Read multiplexer over the register map
  function automatic logic [7:0] reg_read(input hbp_pkg::hbp_state_t s, input logic [4:0] idx,
                                          input logic [7:0] pins, input logic [7:0] ext);
    logic [7:0] r;
    r = ext;
    case (idx)
      hbp_pkg::REG_GPIO_DATA: r = (s.gpio_data & s.direction) | (pins & ~s.direction);
      hbp_pkg::REG_EDGE_SEL: r = s.edge_sel;
      hbp_pkg::REG_DIRECTION: r = s.direction;
      hbp_pkg::REG_ENABLE_A: r = s.enable[15:8];
      hbp_pkg::REG_ENABLE_B: r = s.enable[7:0];
      hbp_pkg::REG_PENDING_A: r = s.pending[15:8];
      hbp_pkg::REG_PENDING_B: r = s.pending[7:0];
      hbp_pkg::REG_INSERVICE_A: r = hbp_pkg::REG_CLEAR;
      hbp_pkg::REG_INSERVICE_B: r = hbp_pkg::REG_CLEAR;
      hbp_pkg::REG_MASK_A: r = s.mask[15:8];
      hbp_pkg::REG_MASK_B: r = s.mask[7:0];
      hbp_pkg::REG_VECTOR: r = s.vector;
      hbp_pkg::REG_TIMER_A_CTRL: r = s.timer_a_ctrl;
      hbp_pkg::REG_TIMER_B_CTRL: r = s.timer_b_ctrl;
      default: r = ext;
    endcase
    return r;
  endfunction

  assign ctl_raw = '{cs_n: cs_n_i, ds_n: data_strobe_n_i, interrupt_ack_n_n: interrupt_ack_n_i,
                     as: addr_strobe_i};

  hbp_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .raw_i(ctl_raw),
    .sync_o(ctl)
  );

  // Per-line edge detection and channel routing
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_line
      if (g == hbp_pkg::TAI_LINE) begin : g_tai
        assign line_src[g] = timer_gated(s_reg.timer_a_ctrl) ? timer_a_control_input_i
                                                             : general_purpose_lines_i[g];
      end else if (g == hbp_pkg::TBI_LINE) begin : g_tbi
        assign line_src[g] = timer_gated(s_reg.timer_b_ctrl) ? timer_b_control_input_i
                                                             : general_purpose_lines_i[g];
      end else begin : g_plain
        assign line_src[g] = general_purpose_lines_i[g];
      end
      assign line_ev[g] = (line_src[g] ^ s_reg.line_prev[g]) &
                          (line_src[g] == s_reg.edge_sel[g]);
    end
    for (g = 0; g < 16; g++) begin : g_chan
      logic hit;
      always_comb begin
        hit = 1'b0;
        for (int k = 0; k < 8; k++) begin
          if (hbp_pkg::GP_CHANNEL_MAP[32 + 4 * k +: 4] == 4'(g)) begin
            hit = hit | line_ev[k];
          end
          if (hbp_pkg::INT_CHANNEL_MAP[4 * k +: 4] == 4'(g)) begin
            hit = hit | internal_event_i[k];
          end
        end
      end
      assign chan_ev[g] = hit;
    end
  endgenerate

  // Pending and unmasked channels, highest wins the vector
  assign active = s_reg.pending & s_reg.mask;

  hbp_prio u_prio (
    .req_i(active),
    .any_o(irq_any),
    .chan_o(irq_chan)
  );

  // Next-state logic for bus cycles, registers and pins
  always_comb begin
    logic [15:0] clr;
    logic [15:0] pend;
    logic [4:0] sel;
    logic commit;
    clr = 16'h0000;
    pend = 16'h0000;
    sel = s_reg.idx;
    commit = 1'b0;
    s_next = s_reg;
    s_next.ext_wr = 1'b0;
    s_next.line_prev = line_src;
    s_next.as_prev = ctl.as;

    // multiplexed address taken as the strobe falls
    if (bus_mux_select_i && s_reg.as_prev && !ctl.as) begin
      s_next.addr_latch = register_select_i;
    end
    // one register from the select lines
    sel = bus_mux_select_i ? s_reg.addr_latch : register_select_i;

    case (s_reg.st)
      hbp_pkg::ST_IDLE: begin
        // answer only under select or chained acknowledge
        if (!ctl.cs_n && !ctl.ds_n) begin
          s_next.idx = sel;
          if (rw_i) begin
            s_next.dout = reg_read(s_reg, sel, general_purpose_lines_i, ext_rdata_i);
            s_next.dout_oe = 1'b1;
            s_next.st = hbp_pkg::ST_READ;
          end else begin
            s_next.wdata = data_i;
            s_next.st = hbp_pkg::ST_WRITE;
          end
          s_next.ack_n = 1'b0;
          s_next.ack_oe = 1'b1;
        end else if (!ctl.interrupt_ack_n_n && !ctl.ds_n) begin
          if (!chain_enable_in_n_i && irq_any) begin
            // vector on the low data byte
            s_next.dout = {s_reg.vector[7:4], irq_chan};
            s_next.dout_oe = 1'b1;
            s_next.ack_n = 1'b0;
            s_next.ack_oe = 1'b1;
            clr[irq_chan] = 1'b1;
            s_next.st = hbp_pkg::ST_INTERRUPT_ACK_N;
          end else begin
            // pass the chain, stay off the bus
            s_next.st = hbp_pkg::ST_PASS;
          end
        end
      end
      hbp_pkg::ST_READ, hbp_pkg::ST_INTERRUPT_ACK_N: begin
        if (ctl.cs_n && ctl.interrupt_ack_n_n || ctl.ds_n) begin
          s_next.dout_oe = 1'b0;
          s_next.ack_n = 1'b1;
          s_next.st = hbp_pkg::ST_END;
        end
      end
      hbp_pkg::ST_WRITE: begin
        if (ctl.cs_n || ctl.ds_n) begin
          // commit the data held at the strobe rise
          commit = 1'b1;
          s_next.ack_n = 1'b1;
          s_next.st = hbp_pkg::ST_END;
        end else if (!cs_n_i && !data_strobe_n_i) begin
          // Raw strobe gates sampling: the synced copy lags past the rise
          s_next.wdata = data_i;
        end
      end
      hbp_pkg::ST_PASS: begin
        if (ctl.interrupt_ack_n_n || ctl.ds_n) begin
          s_next.st = hbp_pkg::ST_IDLE;
        end
      end
      hbp_pkg::ST_END: begin
        s_next.ack_oe = 1'b0;
        s_next.st = hbp_pkg::ST_IDLE;
      end
      default: begin
        s_next.st = hbp_pkg::ST_IDLE;
        s_next.dout_oe = 1'b0;
        s_next.ack_oe = 1'b0;
        s_next.ack_n = 1'b1;
      end
    endcase

    // timer outputs toggle per timer cycle
    s_next.tout = s_reg.tout ^ timer_cycle_i;

    // Register writes; the ack only means the data was held
    if (commit) begin
      case (s_reg.idx)
        hbp_pkg::REG_GPIO_DATA: s_next.gpio_data = s_reg.wdata;
        hbp_pkg::REG_EDGE_SEL: s_next.edge_sel = s_reg.wdata;
        hbp_pkg::REG_DIRECTION: s_next.direction = s_reg.wdata;
        hbp_pkg::REG_ENABLE_A: s_next.enable[15:8] = s_reg.wdata;
        hbp_pkg::REG_ENABLE_B: s_next.enable[7:0] = s_reg.wdata;
        hbp_pkg::REG_PENDING_A: clr[15:8] = clr[15:8] | ~s_reg.wdata;
        hbp_pkg::REG_PENDING_B: clr[7:0] = clr[7:0] | ~s_reg.wdata;
        hbp_pkg::REG_MASK_A: s_next.mask[15:8] = s_reg.wdata;
        hbp_pkg::REG_MASK_B: s_next.mask[7:0] = s_reg.wdata;
        hbp_pkg::REG_VECTOR: s_next.vector = s_reg.wdata;
        hbp_pkg::REG_TIMER_A_CTRL: begin
          s_next.timer_a_ctrl = s_reg.wdata;
          s_next.tout[0] = 1'b0;
        end
        hbp_pkg::REG_TIMER_B_CTRL: begin
          s_next.timer_b_ctrl = s_reg.wdata;
          s_next.tout[1] = 1'b0;
        end
        default: begin
          s_next.ext_wr = !is_local(s_reg.idx);
        end
      endcase
      s_next.ext_idx = s_reg.idx;
      s_next.ext_wdata = s_reg.wdata;
    end

    // Disabled channels hold nothing; a new event beats a clear
    pend = (s_reg.pending & ~clr) | chan_ev;
    s_next.pending = pend & s_next.enable;

    // request from any unmasked pending channel
    s_next.irq_oe = |(s_next.pending & s_next.mask);
    s_next.irq_n = !s_next.irq_oe;
    // chain passes only when nobody here requests
    s_next.chain_out_n = chain_enable_in_n_i | irq_any;
    // DMA requests follow the serial flags
    s_next.rx_req_n = !rx_full_i;
    s_next.tx_req_n = !tx_empty_i;
  end

  // State register; nothing here runs from the timer clock
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      // timers stopped, timer outputs low, channels off
      s_reg <= '0;
      s_reg.st <= hbp_pkg::ST_IDLE;
      s_reg.ack_n <= 1'b1;
      s_reg.irq_n <= 1'b1;
      s_reg.chain_out_n <= 1'b1;
      s_reg.rx_req_n <= 1'b1;
      s_reg.tx_req_n <= 1'b1;
      s_reg.vector <= hbp_pkg::VECTOR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign data_o = s_reg.dout;
  assign data_oe_o = s_reg.dout_oe;
  // acknowledge is optional for the host to use
  assign transfer_ack_n_o = s_reg.ack_n;
  assign transfer_ack_oe_o = s_reg.ack_oe;
  assign irq_n_o = s_reg.irq_n;
  assign irq_oe_o = s_reg.irq_oe;
  assign chain_enable_out_n_o = s_reg.chain_out_n;
  assign general_purpose_lines_o = s_reg.gpio_data;
  assign general_purpose_lines_oe_o = s_reg.direction;
  assign timer_a_output_o = s_reg.tout[0];
  assign timer_b_output_o = s_reg.tout[1];
  assign timer_c_output_o = s_reg.tout[2];
  assign rx_full_dma_req_n_o = s_reg.rx_req_n;
  assign send_empty_dma_req_n_o = s_reg.tx_req_n;
  assign ext_wr_o = s_reg.ext_wr;
  assign ext_idx_o = s_reg.ext_idx;
  assign ext_wdata_o = s_reg.ext_wdata;

endmodule // hbp_host_port
`default_nettype wire

/* verif/hbp_host_port_assertions.sv */
// Checker of the host bus port pin behaviour
`timescale 1ns/1ns
`default_nettype none
module hbp_host_port_assertions (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Host side inputs
  input wire logic cs_n_i,
  input wire logic rw_i,
  input wire logic interrupt_ack_n_i,
  input wire logic chain_enable_in_n_i,
  // Port outputs
  input wire logic data_oe_o,
  input wire logic transfer_ack_n_o,
  input wire logic transfer_ack_oe_o,
  input wire logic irq_n_o,
  input wire logic irq_oe_o,
  input wire logic chain_enable_out_n_o,
  input wire logic [7:0] general_purpose_lines_oe_o,
  input wire logic timer_a_output_o,
  input wire logic ext_wr_o,
  input wire logic [4:0] ext_idx_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Acknowledge phases of one access
  sequence s_ack_low; transfer_ack_oe_o && !transfer_ack_n_o; endsequence
  sequence s_ack_high; transfer_ack_oe_o && transfer_ack_n_o; endsequence
  // Strobes pass two flops, so the cause lies three or four edges back
  property p_ack_cause;
    s_ack_low |-> !$past(cs_n_i, 3) || !$past(cs_n_i, 4)
      || !$past(interrupt_ack_n_i, 3) || !$past(interrupt_ack_n_i, 4);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without select");
  property p_read_data;
    transfer_ack_oe_o && !transfer_ack_n_o && rw_i |-> data_oe_o;
  endproperty
  a_read_data: assert property (p_read_data) else $error("read ack without data");
  property p_end;
    s_ack_low ##1 s_ack_high |-> !data_oe_o ##1 !transfer_ack_oe_o;
  endproperty
  a_end: assert property (p_end) else $error("ack not released");
  property p_irq_od;
    irq_n_o == !irq_oe_o;
  endproperty
  a_irq_od: assert property (p_irq_od) else $error("request level and drive differ");
  property p_chain_out;
    !chain_enable_out_n_o |-> !$past(chain_enable_in_n_i);
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain passed while blocked");
  property p_blocked;
    (cs_n_i && chain_enable_in_n_i) [*6] |-> !transfer_ack_oe_o && !data_oe_o;
  endproperty
  a_blocked: assert property (p_blocked) else $error("bus driven while not chosen");
  property p_reset_state;
    $rose(nrst_i) |-> !irq_oe_o && !transfer_ack_oe_o && !timer_a_output_o
      && general_purpose_lines_oe_o == 8'h00;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
  property p_ext_wr;
    ext_wr_o |-> ext_idx_o >= 5'h0e ##1 !ext_wr_o;
  endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("external write misdecoded");
endmodule // hbp_host_port_assertions
bind hbp_host_port hbp_host_port_assertions u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .cs_n_i(cs_n_i), .rw_i(rw_i), .interrupt_ack_n_i(interrupt_ack_n_i),
  .chain_enable_in_n_i(chain_enable_in_n_i), .data_oe_o(data_oe_o),
  .transfer_ack_n_o(transfer_ack_n_o), .transfer_ack_oe_o(transfer_ack_oe_o),
  .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .chain_enable_out_n_o(chain_enable_out_n_o),
  .general_purpose_lines_oe_o(general_purpose_lines_oe_o),
  .timer_a_output_o(timer_a_output_o), .ext_wr_o(ext_wr_o), .ext_idx_o(ext_idx_o));
`default_nettype wire

/* verif/hbp_host_model.sv */
// Host processor model issuing register and acknowledge cycles
`timescale 1ns/1ns
`default_nettype none
module hbp_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Bus towards the port
  output logic cs_n_o,
  output logic ds_n_o,
  output logic rw_o,
  output logic interrupt_ack_n_n_o,
  output logic [4:0] rs_o,
  output logic [7:0] data_o,
  // Answers from the port
  input wire logic [7:0] data_i,
  input wire logic ack_n_i,
  input wire logic ack_oe_i
);
  // Idle bus at time zero
  initial begin
    cs_n_o = 1'b1;
    ds_n_o = 1'b1;
    rw_o = 1'b1;
    interrupt_ack_n_n_o = 1'b1;
    rs_o = 5'h00;
    data_o = 8'h00;
  end
  // one access, never select and acknowledge together
  task automatic access(input logic ack_cyc, input logic rd, input logic [4:0] idx,
      input logic [7:0] wd, output logic [7:0] rdat, output logic seen);
    int n;
    rdat = 8'h00;
    seen = 1'b0;
    @(negedge ref_clk_i);
    rw_o = rd;
    rs_o = idx;
    data_o = rd ? ~data_o : wd;
    cs_n_o = ack_cyc;
    interrupt_ack_n_n_o = !ack_cyc;
    ds_n_o = 1'b0;
    // Bounded wait; a port that stays silent is judged by the caller
    for (n = 0; n < 20 && !seen; n++) begin
      @(posedge ref_clk_i);
      if (ack_oe_i === 1'b1 && ack_n_i === 1'b0) begin
        seen = 1'b1;
        rdat = data_i;
      end
    end
    @(negedge ref_clk_i);
    cs_n_o = 1'b1;
    interrupt_ack_n_n_o = 1'b1;
    ds_n_o = 1'b1;
    // Released bus must not keep the old value
    data_o = ~data_o;
    repeat (5) @(negedge ref_clk_i);
  endtask
endmodule // hbp_host_model
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench for the host bus port
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic cs_n, ds_n, rw, interrupt_ack_n_n, data_oe, ack_n, ack_oe, irq_n, irq_oe, chain_out_n;
  logic chain_in_n, timer_a_control_input, timer_b_control_input, ta, tb, tc, rx_full, tx_empty, ext_wr;
  logic rx_req_n, tx_req_n;
  logic [4:0] rs, ext_idx;
  logic [7:0] dut_d, host_d, bus, gp_i, gp_o, gp_oe, ievt, ext_rd, ext_wd, dv;
  logic [2:0] tcyc;
  logic [12:0] ext_last;
  logic [7:0] mdl [0:15];
  int bad_count = 0;
  int num_checks = 0;
  int i, j;
  int idxs [7] = '{1, 2, 9, 10, 11, 12, 13};
  // Clock at 100 MHz
  always #5 ref_clk_i = ~ref_clk_i;
  // Shared data wire: the port wins while it drives
  assign bus = data_oe ? dut_d : host_d;
  hbp_host_model host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .ds_n_o(ds_n), .rw_o(rw),
    .interrupt_ack_n_n_o(interrupt_ack_n_n), .rs_o(rs), .data_o(host_d), .data_i(bus), .ack_n_i(ack_n),
    .ack_oe_i(ack_oe));
  hbp_host_port DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
    .data_strobe_n_i(ds_n), .rw_i(rw), .register_select_i(rs), .bus_mux_select_i(1'b0),
    .addr_strobe_i(1'b0), .data_i(bus), .data_o(dut_d), .data_oe_o(data_oe),
    .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(ack_oe), .irq_n_o(irq_n),
    .irq_oe_o(irq_oe), .interrupt_ack_n_i(interrupt_ack_n_n), .chain_enable_in_n_i(chain_in_n),
    .chain_enable_out_n_o(chain_out_n), .general_purpose_lines_i(gp_i),
    .general_purpose_lines_o(gp_o), .general_purpose_lines_oe_o(gp_oe),
    .timer_a_control_input_i(timer_a_control_input), .timer_b_control_input_i(timer_b_control_input), .timer_cycle_i(tcyc),
    .timer_a_output_o(ta), .timer_b_output_o(tb), .timer_c_output_o(tc),
    .rx_full_i(rx_full), .tx_empty_i(tx_empty), .internal_event_i(ievt),
    .rx_full_dma_req_n_o(rx_req_n), .send_empty_dma_req_n_o(tx_req_n),
    .ext_rdata_i(ext_rd), .ext_wr_o(ext_wr), .ext_idx_o(ext_idx), .ext_wdata_o(ext_wd));
  // Record external register writes
  always @(posedge ref_clk_i) begin
    if (ext_wr === 1'b1) begin
      ext_last <= {ext_idx, ext_wd};
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", nm, e, g);
      bad_count++;
    end
  endtask
  // Bus cycles through the host model
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic s;
    host.access(1'b0, 1'b0, idx, d, r, s);
    chk("wr_ack", 13'h1, {12'h0, s});
    if (idx < 5'h10) mdl[idx[3:0]] = d;
  endtask
  task automatic rd(input logic [4:0] idx, input logic [7:0] e);
    logic [7:0] r;
    logic s;
    host.access(1'b0, 1'b1, idx, 8'h00, r, s);
    chk("rd_ack", 13'h1, {12'h0, s});
    chk("rdata", {5'h0, e}, {5'h0, r});
  endtask
  task automatic interrupt_ack_n(input logic e, input logic [7:0] v);
    logic [7:0] r;
    logic s;
    host.access(1'b1, 1'b1, 5'h00, 8'h00, r, s);
    chk("interrupt_ack_n_ack", {12'h0, e}, {12'h0, s});
    if (e) chk("vector", {5'h0, v}, {5'h0, r});
  endtask
  // One-cycle pulses on timer cycles and internal events, then settle
  task automatic pulse(input logic [10:0] v);
    @(negedge ref_clk_i);
    {tcyc, ievt} = v;
    @(negedge ref_clk_i);
    {tcyc, ievt} = 11'h000;
    repeat (3) @(negedge ref_clk_i);
  endtask
  // Hang guard
  initial begin
    #900000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {chain_in_n, gp_i, tcyc, ievt, ext_rd, ext_last} = '0;
    for (i = 0; i < 16; i++) mdl[i] = 8'h00;
    mdl[11] = 8'h0f;
    void'($urandom(32'hd663));
    {timer_a_control_input, timer_b_control_input, rx_full, tx_empty} = 4'($urandom());
    repeat (5) @(negedge ref_clk_i);
    nrst_i = 1'b1;
    chk("irq_n", 13'h1, {12'h0, irq_n});
    chk("lines_oe", 13'h0, {5'h0, gp_oe});
    chk("timers", 13'h0, {10'h0, ta, tb, tc});
    for (i = 1; i < 14; i++) rd(i[4:0], mdl[i]);
    for (i = 0; i < 2; i++) begin
      chk("rx_dma", {12'h0, ~rx_full}, {12'h0, rx_req_n});
      chk("tx_dma", {12'h0, ~tx_empty}, {12'h0, tx_req_n});
      rx_full = ~rx_full;
      tx_empty = ~tx_empty;
      repeat (2) @(negedge ref_clk_i);
    end
    for (i = 0; i < 14; i++) begin
      j = idxs[i % 7];
      wr(j[4:0], 8'($urandom()));
      rd(j[4:0], mdl[j]);
    end
    chk("lines_oe", {5'h0, mdl[2]}, {5'h0, gp_oe});
    wr(5'h00, 8'h5a);
    chk("lines_out", 13'h5a, {5'h0, gp_o});
    dv = 8'($urandom());
    ext_rd = ~dv;
    wr(5'h14, dv);
    chk("ext_write", {5'h14, dv}, ext_last);
    rd(5'h15, ~dv);
    wr(5'h02, 8'h00);
    wr(5'h01, 8'h02);
    wr(5'h0a, 8'h12);
    wr(5'h04, 8'h12);
    wr(5'h0b, 8'h40);
    pulse(11'h001);
    chk("irq_n", 13'h0, {12'h0, irq_n});
    chk("chain_out", 13'h1, {12'h0, chain_out_n});
    interrupt_ack_n(1'b1, 8'h44);
    chk("irq_n", 13'h1, {12'h0, irq_n});
    chk("chain_out", 13'h0, {12'h0, chain_out_n});
    pulse(11'h001);
    wr(5'h0a, 8'h02);
    chk("irq_n", 13'h1, {12'h0, irq_n});
    wr(5'h0a, 8'h12);
    chk("irq_n", 13'h0, {12'h0, irq_n});
    wr(5'h06, 8'h00);
    chk("irq_n", 13'h1, {12'h0, irq_n});
    chain_in_n = 1'b1;
    pulse(11'h001);
    interrupt_ack_n(1'b0, 8'h00);
    chk("chain_out", 13'h1, {12'h0, chain_out_n});
    chain_in_n = 1'b0;
    gp_i = 8'h02;
    repeat (4) @(negedge ref_clk_i);
    interrupt_ack_n(1'b1, 8'h44);
    chk("irq_n", 13'h0, {12'h0, irq_n});
    interrupt_ack_n(1'b1, 8'h41);
    chk("irq_n", 13'h1, {12'h0, irq_n});
    for (i = 0; i < 2; i++) begin
      pulse(11'h100 << i);
      chk("timer_out", 13'h1, {12'h0, i ? tb : ta});
      pulse(11'h100 << i);
      chk("timer_out", 13'h0, {12'h0, i ? tb : ta});
      pulse(11'h100 << i);
      wr(5'h0c + i[4:0], 8'h00);
      chk("timer_out", 13'h0, {12'h0, i ? tb : ta});
    end
    pulse(11'h400);
    chk("timer_c", 13'h1, {12'h0, tc});
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
